// File: rtl/mmc_ctrl.sv
// Management control: flags, interrupt, select, power-down, laser enable
// Notes on behaviour
// - Condition sets flag and raises interrupt promptly
// - Setting mask bit inhibits that flag's interrupt
// - Clearing mask bit lets flag interrupt again
// - Selected module answers serial bus promptly
// - Deselected module stops answering serial bus promptly
// - Power-down bit set enters low power
// - Power-down bit cleared returns to full function
// - Full function: not-ready cleared, interrupt raised
// - Write effects timed from falling clock after stop
// - Read effects timed from falling clock after stop
// - Transmit disable high or open turns laser off
// - Clear-on-read of flag releases interrupt promptly
//
// Added by the designer: the placing of the registers and the strobed register port.
module mmc_ctrl
    import mmc_pkg::*;
#(
    parameter int WAKE_CYCLES = WAKE_CYCLES_DEF
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic module_select_n,
    input wire logic module_reset_n,
    input wire logic low_power_pin,
    input wire logic transmit_disable,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic [FLAG_W-1:0] flag_event,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    output logic interrupt_request_n,
    output logic module_present_n,
    output logic laser_enable,
    output logic low_power_state
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [PIN_N-1:0] pin_meta, pin_sync;
    logic sel_n_s, mrst_n_s, lp_s, transmit_disable_s, soft_rst;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pin_meta <= PIN_RESET;
            pin_sync <= PIN_RESET;
        end else begin
            pin_meta <= {module_select_n, module_reset_n,
                         low_power_pin, transmit_disable};
            pin_sync <= pin_meta;
        end
    end

    assign sel_n_s = pin_sync[PIN_SEL];
    assign mrst_n_s = pin_sync[PIN_MRST];
    assign lp_s = pin_sync[PIN_LP];
    assign transmit_disable_s = pin_sync[PIN_TRANSMIT_DISABLE];
    assign soft_rst = ~mrst_n_s;

    // ------------------------------------------------------------
    // Serial bus watcher
    // ------------------------------------------------------------
    logic stop_fall, stop_was_read, commit_wr, commit_rd;

    mmc_serial_watch u_watch (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .respond(~sel_n_s),
        .sda_out(sda_out),
        .sda_oe_n(sda_oe_n),
        .stop_fall(stop_fall),
        .stop_was_read(stop_was_read)
    );

    // Register side effects wait for the bus reference edge
    assign commit_wr = stop_fall & ~stop_was_read;
    assign commit_rd = stop_fall & stop_was_read;

    // ------------------------------------------------------------
    // Power and readiness sequence
    // ------------------------------------------------------------
    typedef enum logic [1:0] {ST_WAKING, ST_READY, ST_LOWPOWER} mmc_state_t;

    mmc_state_t state, next_state;
    logic [WAKE_CNT_W-1:0] wake_cnt, next_wake_cnt;
    logic not_ready, next_not_ready, ready_evt, lp_req, pdown;
    logic next_lp_out, next_laser;

    assign lp_req = pdown | lp_s;

    always_comb begin
        next_state = state;
        next_wake_cnt = wake_cnt;
        next_not_ready = not_ready;
        ready_evt = 1'b0;
        unique case (state)
            ST_WAKING: begin
                if (lp_req) begin
                    next_state = ST_LOWPOWER;
                end else if (wake_cnt ==
                             WAKE_CNT_W'(WAKE_CYCLES - 1)) begin
                    next_state = ST_READY;
                    next_not_ready = 1'b0;
                    ready_evt = 1'b1;
                end else begin
                    next_wake_cnt = wake_cnt + 1'b1;
                end
            end
            ST_READY: begin
                if (lp_req) begin
                    next_state = ST_LOWPOWER;
                    next_not_ready = 1'b1;
                end
            end
            ST_LOWPOWER: begin
                if (!lp_req) begin
                    next_state = ST_WAKING;
                    next_wake_cnt = '0;
                end
            end
        endcase
        if (soft_rst) begin
            next_state = ST_WAKING;
            next_wake_cnt = '0;
            next_not_ready = 1'b1;
            ready_evt = 1'b0;
        end
        next_lp_out = (next_state == ST_LOWPOWER);
        // Open input reads high through the board pull-up
        next_laser = ~transmit_disable_s;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_WAKING;
            wake_cnt <= '0;
            not_ready <= 1'b1;
            low_power_state <= 1'b0;
            laser_enable <= 1'b0;
        end else begin
            state <= next_state;
            wake_cnt <= next_wake_cnt;
            not_ready <= next_not_ready;
            low_power_state <= next_lp_out;
            laser_enable <= next_laser;
        end
    end

    // ------------------------------------------------------------
    // Registers, flags and interrupt
    // ------------------------------------------------------------
    logic [DATA_W-1:0] flags, mask, pend_mask, pend_w1c, pend_cor;
    logic [DATA_W-1:0] next_flags, next_mask, next_pend_mask;
    logic [DATA_W-1:0] next_pend_w1c, next_pend_cor, next_rdata;
    logic [DATA_W-1:0] set_evt, clr;
    logic pend_mask_v, pend_pdown, pend_pdown_v;
    logic next_pend_mask_v, next_pend_pdown, next_pend_pdown_v;
    logic next_pdown, next_int_n;

    always_comb begin
        set_evt = '0;
        set_evt[FLAG_W-1:0] = flag_event;
        set_evt[READY_EVT_BIT] = ready_evt;
        next_mask = mask;
        next_pdown = pdown;
        next_pend_mask = pend_mask;
        next_pend_mask_v = pend_mask_v;
        next_pend_pdown = pend_pdown;
        next_pend_pdown_v = pend_pdown_v;
        next_pend_w1c = pend_w1c;
        next_pend_cor = pend_cor;
        next_rdata = '0;
        clr = '0;
        if (commit_wr) begin
            if (pend_mask_v) begin
                next_mask = pend_mask;
            end
            if (pend_pdown_v) begin
                next_pdown = pend_pdown;
            end
            next_pend_mask_v = 1'b0;
            next_pend_pdown_v = 1'b0;
            next_pend_cor = pend_cor & ~pend_w1c;
            clr = pend_w1c;
            next_pend_w1c = '0;
        end
        if (commit_rd) begin
            clr = clr | pend_cor;
            next_pend_cor = '0;
        end
        if (reg_wr) begin
            unique case (reg_addr)
                REG_FLAGS: next_pend_w1c = next_pend_w1c | reg_wdata;
                REG_MASK: begin
                    next_pend_mask = reg_wdata;
                    next_pend_mask_v = 1'b1;
                end
                REG_CTRL: begin
                    next_pend_pdown = reg_wdata[PDOWN_BIT];
                    next_pend_pdown_v = 1'b1;
                end
                default: ;
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                REG_STATUS: next_rdata[NOT_READY_BIT] = not_ready;
                REG_FLAGS: begin
                    next_rdata = flags;
                    // Only bits actually seen by the reader are cleared
                    next_pend_cor = next_pend_cor | (flags & ~clr);
                end
                REG_MASK: next_rdata = mask;
                REG_CTRL: begin
                    next_rdata[PDOWN_BIT] = pdown;
                    next_rdata[LP_PIN_BIT] = lp_s;
                end
                default: ;
            endcase
        end
        // A new event beats a clear in the same cycle
        next_flags = (flags & ~clr) | set_evt;
        // Unmasked pending flag drives the line low
        next_int_n = ~|(flags & ~mask);
        if (soft_rst) begin
            next_flags = FLAGS_RESET;
            next_mask = MASK_RESET;
            next_pdown = 1'b0;
            next_pend_mask_v = 1'b0;
            next_pend_pdown_v = 1'b0;
            next_pend_w1c = '0;
            next_pend_cor = '0;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            flags <= FLAGS_RESET;
            mask <= MASK_RESET;
            pdown <= 1'b0;
            pend_mask <= MASK_RESET;
            pend_mask_v <= 1'b0;
            pend_pdown <= 1'b0;
            pend_pdown_v <= 1'b0;
            pend_w1c <= '0;
            pend_cor <= '0;
            reg_rdata <= '0;
            interrupt_request_n <= 1'b1;
        end else begin
            flags <= next_flags;
            mask <= next_mask;
            pdown <= next_pdown;
            pend_mask <= next_pend_mask;
            pend_mask_v <= next_pend_mask_v;
            pend_pdown <= next_pend_pdown;
            pend_pdown_v <= next_pend_pdown_v;
            pend_w1c <= next_pend_w1c;
            pend_cor <= next_pend_cor;
            reg_rdata <= next_rdata;
            interrupt_request_n <= next_int_n;
        end
    end

    // Presence pin is strapped low inside the module
    assign module_present_n = 1'b0;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    chk_flag_set: assert property (
        (|flag_event && !soft_rst) |=>
        ((flags[FLAG_W-1:0] & $past(flag_event)) == $past(flag_event)))
        else $error("flag event not latched");

    chk_int_assert: assert property (
        (|(flags & ~mask)) |=> !interrupt_request_n)
        else $error("interrupt not asserted for unmasked flag");

    chk_int_release: assert property (
        ((flags & ~mask) == '0) |=> interrupt_request_n)
        else $error("interrupt held with nothing pending");

    chk_mask_commit: assert property (
        (commit_wr && pend_mask_v && !soft_rst) |=>
        (mask == $past(pend_mask)))
        else $error("mask change not applied to interrupt");

    chk_cor_clear: assert property (
        (commit_rd && !soft_rst && !reg_rd && (set_evt & pend_cor) == '0)
        |=> ((flags & $past(pend_cor)) == '0))
        else $error("clear on read not applied");

    chk_pdown_enter: assert property (
        (commit_wr && pend_pdown_v && pend_pdown && !soft_rst)
        |-> ##[1:3] low_power_state)
        else $error("power-down not entered");

    chk_ready_irq: assert property (
        ($fell(not_ready) && !soft_rst) |->
        flags[READY_EVT_BIT] ##1 (mask[READY_EVT_BIT] || !interrupt_request_n))
        else $error("ready not signalled by interrupt");

    chk_wake_done: assert property (
        (state == ST_WAKING && !lp_req && !soft_rst &&
         wake_cnt == WAKE_CNT_W'(WAKE_CYCLES - 1))
        |=> (state == ST_READY && !not_ready && !low_power_state))
        else $error("wake sequence did not finish");

    chk_laser_off: assert property (
        transmit_disable_s |=> !laser_enable)
        else $error("laser enabled while transmit disabled");

    chk_deselect: assert property (
        module_select_n [*4] |-> sda_oe_n)
        else $error("serial bus answered while deselected");

endmodule : mmc_ctrl

// File: rtl/mmc_pkg.sv
// Shared constants for the module management control block
package mmc_pkg;

    // ------------------------------------------------------------
    // Register port and map
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h02;
    localparam logic [ADDR_W-1:0] REG_FLAGS = 8'h03;
    localparam logic [ADDR_W-1:0] REG_MASK = 8'h04;
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h05;
    localparam int NOT_READY_BIT = 0;
    localparam int PDOWN_BIT = 0;
    localparam int LP_PIN_BIT = 1;
    localparam int FLAG_W = 7;
    localparam int READY_EVT_BIT = 7;
    localparam logic [DATA_W-1:0] FLAGS_RESET = 8'h00;
    localparam logic [DATA_W-1:0] MASK_RESET = 8'h00;

    // ------------------------------------------------------------
    // Pins sampled from outside the clock domain
    // ------------------------------------------------------------
    localparam int PIN_N = 4;
    localparam int PIN_SEL = 3;
    localparam int PIN_MRST = 2;
    localparam int PIN_LP = 1;
    localparam int PIN_TRANSMIT_DISABLE = 0;
    localparam logic [PIN_N-1:0] PIN_RESET = 4'h9;

    // ------------------------------------------------------------
    // 2-wire bus
    // ------------------------------------------------------------
    localparam logic [6:0] SERIAL_ADDR = 7'h50;
    localparam int BYTE_BITS = 8;
    localparam int BIT_CNT_W = 4;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 25_000_000;
    localparam int WAKE_TIME_MS = 300;
    localparam int WAKE_CYCLES_DEF = WAKE_TIME_MS * (CLK_HZ / 1000);
    localparam int WAKE_CNT_W = 24;

endpackage : mmc_pkg

// File: rtl/mmc_serial_watch.sv
// 2-wire bus watcher: address acknowledge and stop reference edge
module mmc_serial_watch
    import mmc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic respond,
    output logic sda_out,
    output logic sda_oe_n,
    output logic stop_fall,
    output logic stop_was_read
);

    // ------------------------------------------------------------
    // Synchronisers and edges
    // ------------------------------------------------------------
    logic scl_meta, scl_sync, scl_last;
    logic sda_meta, sda_sync, sda_last;
    logic scl_rise, scl_fall, start, stop;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            scl_meta <= 1'b1;
            scl_sync <= 1'b1;
            scl_last <= 1'b1;
            sda_meta <= 1'b1;
            sda_sync <= 1'b1;
            sda_last <= 1'b1;
        end else begin
            scl_meta <= scl_in;
            scl_sync <= scl_meta;
            scl_last <= scl_sync;
            sda_meta <= sda_in;
            sda_sync <= sda_meta;
            sda_last <= sda_sync;
        end
    end

    assign scl_rise = scl_sync & ~scl_last;
    assign scl_fall = ~scl_sync & scl_last;
    assign start = scl_sync & scl_last & ~sda_sync & sda_last;
    assign stop = scl_sync & scl_last & sda_sync & ~sda_last;

    // ------------------------------------------------------------
    // Frame tracking
    // ------------------------------------------------------------
    logic in_frame, first_byte, addr_ok, rw, ack, stop_seen;
    logic next_in_frame, next_first_byte, next_addr_ok, next_rw;
    logic next_ack, next_stop_seen, next_stop_fall, next_was_read;
    logic [BIT_CNT_W-1:0] bit_cnt, next_bit_cnt;
    logic [BYTE_BITS-1:0] shreg, next_shreg;

    always_comb begin
        next_in_frame = in_frame;
        next_first_byte = first_byte;
        next_addr_ok = addr_ok;
        next_rw = rw;
        next_ack = ack;
        next_stop_seen = stop_seen;
        next_stop_fall = 1'b0;
        next_was_read = stop_was_read;
        next_bit_cnt = bit_cnt;
        next_shreg = shreg;
        if (start) begin
            next_in_frame = 1'b1;
            next_first_byte = 1'b1;
            next_addr_ok = 1'b0;
            next_ack = 1'b0;
            next_bit_cnt = '0;
        end else if (stop) begin
            // Only transfers aimed at us give a reference edge
            next_in_frame = 1'b0;
            next_ack = 1'b0;
            next_stop_seen = addr_ok;
        end else begin
            if (scl_rise && in_frame && bit_cnt <= BIT_CNT_W'(BYTE_BITS)) begin
                if (bit_cnt < BIT_CNT_W'(BYTE_BITS)) begin
                    next_shreg = {shreg[BYTE_BITS-2:0], sda_sync};
                end
                next_bit_cnt = bit_cnt + 1'b1;
            end
            if (scl_fall && stop_seen) begin
                next_stop_fall = 1'b1;
                next_stop_seen = 1'b0;
                next_was_read = rw;
            end else if (scl_fall && in_frame) begin
                if (bit_cnt == BIT_CNT_W'(BYTE_BITS)) begin
                    if (first_byte) begin
                        next_addr_ok = respond &&
                            shreg[BYTE_BITS-1:1] == SERIAL_ADDR;
                        next_rw = shreg[0];
                        next_ack = next_addr_ok;
                    end else begin
                        // Read data is not served here; bytes read as ones
                        next_ack = addr_ok & respond & ~rw;
                    end
                end else if (bit_cnt == BIT_CNT_W'(BYTE_BITS + 1)) begin
                    next_ack = 1'b0;
                    next_bit_cnt = '0;
                    next_first_byte = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            in_frame <= 1'b0;
            first_byte <= 1'b0;
            addr_ok <= 1'b0;
            rw <= 1'b0;
            ack <= 1'b0;
            stop_seen <= 1'b0;
            stop_fall <= 1'b0;
            stop_was_read <= 1'b0;
            bit_cnt <= '0;
            shreg <= '0;
        end else begin
            in_frame <= next_in_frame;
            first_byte <= next_first_byte;
            addr_ok <= next_addr_ok;
            rw <= next_rw;
            ack <= next_ack;
            stop_seen <= next_stop_seen;
            stop_fall <= next_stop_fall;
            stop_was_read <= next_was_read;
            bit_cnt <= next_bit_cnt;
            shreg <= next_shreg;
        end
    end

    // Dropping select releases the line at once, mid-bit if need be
    assign sda_out = 1'b0;
    assign sda_oe_n = ~(ack & respond);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    chk_stop_edge: assert property (
        stop_fall |-> $past(scl_last) && !$past(scl_sync))
        else $error("stop reference not on a falling clock edge");

    chk_addr_ack: assert property (
        (scl_fall && in_frame && first_byte && !start && !stop &&
         !stop_seen && bit_cnt == BIT_CNT_W'(BYTE_BITS) && respond &&
         shreg[BYTE_BITS-1:1] == SERIAL_ADDR)
        |=> (!sda_oe_n || !respond))
        else $error("own address not acknowledged");

endmodule : mmc_serial_watch

// File: sim/mmc_host.sv
// Host-side 2-wire bus master model for the management block bench
module mmc_host (
    output logic scl,
    output logic sda_rel,
    input wire logic sda_line
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // Bus timing, 320 ns serial clock
    // ----------------------------------------
    localparam int Q = 80;
    logic got_ack;
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
        got_ack = 1'b0;
    end
    // Data moves only while the clock is low; ones are released, not driven
    task automatic put_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            sda_rel = b[i];
            #Q scl = 1'b1;
            #(2*Q) scl = 1'b0;
            #Q;
        end
        sda_rel = 1'b1;
        #Q scl = 1'b1;
        #Q got_ack = ~sda_line;
        #Q scl = 1'b0;
        #Q;
    endtask : put_byte
    // Start, address, one data byte, stop, then the reference clock fall
    task automatic frame(input logic [6:0] a, input logic r, output logic ack);
        #13 sda_rel = 1'b0;
        #Q scl = 1'b0;
        #Q put_byte({a, r});
        ack = got_ack;
        put_byte(r ? 8'hff : 8'h5a);
        sda_rel = 1'b0;
        #Q scl = 1'b1;
        #Q sda_rel = 1'b1;
        #Q scl = 1'b0;
        #Q scl = 1'b1;
    endtask : frame
endmodule : mmc_host

// File: sim/tb.sv
// Self-checking bench for the management control block
module tb
    import mmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic module_select_n = 1'b0;
    logic module_reset_n = 1'b1;
    logic low_power_pin = 1'b0;
    logic transmit_disable = 1'b1;
    logic [FLAG_W-1:0] flag_event = '0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic sda_out, sda_oe_n, interrupt_request_n, module_present_n;
    logic laser_enable, low_power_state, scl, sda_rel, ack;
    wire sda_line = sda_rel & (sda_oe_n | sda_out);
    int error_cnt = 0;
    int n_tests = 0;
    always #20 clk_sys = ~clk_sys;
    mmc_host host_u (.scl(scl), .sda_rel(sda_rel), .sda_line(sda_line));
    // Short wake count keeps the run to a few thousand cycles
    mmc_ctrl #(.WAKE_CYCLES(20)) dut_u (
        .clk_sys(clk_sys), .reset_n(reset_n),
        .module_select_n(module_select_n), .module_reset_n(module_reset_n),
        .low_power_pin(low_power_pin), .transmit_disable(transmit_disable),
        .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .flag_event(flag_event), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .interrupt_request_n(interrupt_request_n),
        .module_present_n(module_present_n), .laser_enable(laser_enable),
        .low_power_state(low_power_state)
    );
    // ----------------------------------------
    // Checks and bus tasks
    // ----------------------------------------
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic chk_pin(input logic g, input logic e);
        chk({7'h00, g}, {7'h00, e});
    endtask : chk_pin
    function automatic logic sig(input int k);
        case (k)
            0: return interrupt_request_n;
            1: return low_power_state;
            default: return laser_enable;
        endcase
    endfunction : sig
    // Bounded wait; running out counts a mismatch and ends the run
    task automatic wait_for(input int k, input logic v);
        int n;
        n = 0;
        while (sig(k) !== v && n < 3000) begin
            @(negedge clk_sys);
            n++;
        end
        chk_pin(sig(k), v);
        if (n >= 3000) end_sim();
    endtask : wait_for
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        chk(reg_rdata, e);
    endtask : rd
    // Register writes only take hold at the serial commit point
    task automatic commit(input logic r);
        host_u.frame(SERIAL_ADDR, r, ack);
    endtask : commit
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rd(REG_STATUS, 8'h01);
        wait_for(0, 1'b0);
        rd(REG_STATUS, 8'h00);
        rd(REG_FLAGS, 8'h80);
        $display("test wake done");
        wr(REG_FLAGS, 8'h80);
        commit(1'b0);
        chk_pin(ack, 1'b1);
        wait_for(0, 1'b1);
        @(posedge clk_sys);
        flag_event <= 7'h24;
        @(posedge clk_sys);
        flag_event <= '0;
        wait_for(0, 1'b0);
        wr(REG_MASK, 8'h04);
        commit(1'b0);
        repeat (12) @(negedge clk_sys);
        chk_pin(interrupt_request_n, 1'b0);
        wr(REG_MASK, 8'h24);
        commit(1'b0);
        wait_for(0, 1'b1);
        wr(REG_MASK, 8'h00);
        commit(1'b0);
        wait_for(0, 1'b0);
        rd(REG_FLAGS, 8'h24);
        commit(1'b1);
        wait_for(0, 1'b1);
        rd(REG_FLAGS, 8'h00);
        $display("test flags done");
        @(posedge clk_sys);
        module_select_n <= 1'b1;
        repeat (8) @(posedge clk_sys);
        commit(1'b0);
        chk_pin(ack, 1'b0);
        @(posedge clk_sys);
        module_select_n <= 1'b0;
        repeat (8) @(posedge clk_sys);
        commit(1'b0);
        chk_pin(ack, 1'b1);
        $display("test select done");
        wr(REG_CTRL, 8'h01);
        commit(1'b0);
        wait_for(1, 1'b1);
        rd(REG_CTRL, 8'h01);
        wr(REG_CTRL, 8'h00);
        commit(1'b0);
        wait_for(1, 1'b0);
        wait_for(0, 1'b0);
        wr(REG_STATUS, 8'hff);
        rd(REG_STATUS, 8'h00);
        rd(8'h7f, 8'h00);
        $display("test power done");
        wait_for(2, 1'b0);
        @(posedge clk_sys);
        transmit_disable <= 1'b0;
        wait_for(2, 1'b1);
        @(posedge clk_sys);
        transmit_disable <= 1'b1;
        wait_for(2, 1'b0);
        $display("test laser done");
        chk_pin(module_present_n, 1'b0);
        @(posedge clk_sys);
        low_power_pin <= 1'b1;
        wait_for(1, 1'b1);
        rd(REG_CTRL, 8'h02);
        @(posedge clk_sys);
        low_power_pin <= 1'b0;
        wait_for(1, 1'b0);
        @(posedge clk_sys);
        module_reset_n <= 1'b0;
        wait_for(0, 1'b1);
        rd(REG_STATUS, 8'h01);
        @(posedge clk_sys);
        module_reset_n <= 1'b1;
        wait_for(0, 1'b0);
        rd(REG_FLAGS, 8'h80);
        @(posedge clk_sys);
        reset_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rd(REG_FLAGS, 8'h00);
        chk_pin(interrupt_request_n, 1'b1);
        wait_for(0, 1'b0);
        $display("test resets done");
        end_sim();
    end
endmodule : tb
